/* cot_timing_regs.sv */
// Output clock and data timing register set with its serial port
// How it works
// - Bit 7 of the clock phase register inverts the output data clock only, not the input divider clock.
// - Bits 2:0 of the clock phase register delay the input divider by that many input clocks.
// - In the output delay register bit 7 enables fine delay on the clock and bit 5 on data.
// - Bits 2:0 of the output delay register pick the fine step and touch only output timing.
// - Bits 2:0 of the reference register pick the input span and reset to code 100.
// - Two 16-bit user patterns sit as low and high bytes in four registers, all reset zero.
// - Every register here takes effect right after its write, with no transfer command.
`timescale 1ns/1ps
`include "cot_params.svh"
module cot_timing_regs (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Serial control port
    input wire logic sclk,
    input wire logic csb,
    input wire logic sdio_i,
    output logic sdio_o,
    output logic sdio_oe_b,
    // Clock timing
    output logic input_divider_clock,
    output logic output_data_clock,
    // Fine output delay
    output logic clock_delay_en,
    output logic data_delay_en,
    output logic [2:0] fine_delay_sel,
    // Reference and patterns
    output logic [2:0] reference_span_code,
    output logic [15:0] pattern_one,
    output logic [15:0] pattern_two
);
    function automatic logic hit(input logic [12:0] a, input logic [12:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    cot_reg_if rif ();

    logic invert;
    logic [2:0] phase_sel;
    logic [2:0] div_cnt;
    logic [7:0] hist;
    logic div_phase_clk;
    logic [7:0] next_rdata;

    cot_spi_port u_port (
        .mclk(mclk),
        .rst_b(rst_b),
        .sclk(sclk),
        .csb(csb),
        .sdio_i(sdio_i),
        .sdio_o(sdio_o),
        .sdio_oe_b(sdio_oe_b),
        .rif(rif)
    );

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            invert <= 1'b0;
            phase_sel <= `COT_RST_FIELD;
        end else if (rif.wr && hit(rif.addr, `COT_OFS_CLK_PHASE)) begin
            invert <= rif.wdata[`COT_BIT_INVERT];
            phase_sel <= rif.wdata[`COT_FLD_HI:`COT_FLD_LO];
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            clock_delay_en <= 1'b0;
            data_delay_en <= 1'b0;
            fine_delay_sel <= `COT_RST_FIELD;
        end else if (rif.wr && hit(rif.addr, `COT_OFS_OUT_DELAY)) begin
            clock_delay_en <= rif.wdata[`COT_BIT_CLK_DLY];
            data_delay_en <= rif.wdata[`COT_BIT_DATA_DLY];
            fine_delay_sel <= rif.wdata[`COT_FLD_HI:`COT_FLD_LO];
        end
    end

    // span code, reset to largest span
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reference_span_code <= `COT_RST_SPAN;
        end else if (rif.wr && hit(rif.addr, `COT_OFS_REF_SPAN)) begin
            reference_span_code <= rif.wdata[`COT_FLD_HI:`COT_FLD_LO];
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pattern_one <= {`COT_RST_BYTE, `COT_RST_BYTE};
            pattern_two <= {`COT_RST_BYTE, `COT_RST_BYTE};
        end else if (rif.wr) begin
            if (hit(rif.addr, `COT_OFS_PAT1_LO)) begin
                pattern_one[7:0] <= rif.wdata;
            end
            if (hit(rif.addr, `COT_OFS_PAT1_HI)) begin
                pattern_one[15:8] <= rif.wdata;
            end
            if (hit(rif.addr, `COT_OFS_PAT2_LO)) begin
                pattern_two[7:0] <= rif.wdata;
            end
            if (hit(rif.addr, `COT_OFS_PAT2_HI)) begin
                pattern_two[15:8] <= rif.wdata;
            end
        end
    end

    // Open bits read back as zero; unmapped addresses read zero
    always_comb begin
        next_rdata = `COT_READ_NONE;
        case (rif.addr)
            `COT_OFS_CLK_PHASE: next_rdata = {invert, 4'h0, phase_sel};
            `COT_OFS_OUT_DELAY: next_rdata = {clock_delay_en, 1'b0, data_delay_en, 2'h0,
                fine_delay_sel};
            `COT_OFS_REF_SPAN: next_rdata = {5'h00, reference_span_code};
            `COT_OFS_PAT1_LO: next_rdata = pattern_one[7:0];
            `COT_OFS_PAT1_HI: next_rdata = pattern_one[15:8];
            `COT_OFS_PAT2_LO: next_rdata = pattern_two[7:0];
            `COT_OFS_PAT2_HI: next_rdata = pattern_two[15:8];
            default: next_rdata = `COT_READ_NONE;
        endcase
    end
    assign rif.rdata = next_rdata;

    // divider phase taken from a history of the undelayed divider
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt <= 3'h0;
            hist <= `COT_RST_BYTE;
            div_phase_clk <= 1'b0;
        end else begin
            div_cnt <= div_cnt + 3'h1;
            hist <= {hist[6:0], div_cnt[`COT_DIV_MSB]};
            div_phase_clk <= hist[phase_sel];
        end
    end

    // invert sits after the phase tap, so sampling is untouched
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            input_divider_clock <= 1'b0;
            output_data_clock <= 1'b0;
        end else begin
            input_divider_clock <= div_phase_clk;
            output_data_clock <= div_phase_clk ^ invert;
        end
    end

    // Checks on the live behaviour
    logic first_after_reset;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            first_after_reset <= 1'b1;
        end else begin
            first_after_reset <= 1'b0;
        end
    end

    property p_invert;
        @(posedge mclk) disable iff (!rst_b)
        output_data_clock == (input_divider_clock ^ $past(invert));
    endproperty
    a_invert: assert property (p_invert) else $error("output clock polarity wrong");

    property p_phase3;
        @(posedge mclk) disable iff (!rst_b)
        (phase_sel == 3'h3) [*8] |-> (div_phase_clk == $past(div_cnt[2], 5));
    endproperty
    a_phase3: assert property (p_phase3) else $error("divider phase 3 wrong");

    property p_phase7;
        @(posedge mclk) disable iff (!rst_b)
        (phase_sel == 3'h7) [*8] |-> (div_phase_clk == $past(div_cnt[2], 9));
    endproperty
    a_phase7: assert property (p_phase7) else $error("divider phase 7 wrong");

    property p_delay_en;
        @(posedge mclk) disable iff (!rst_b)
        (rif.wr && rif.addr == `COT_OFS_OUT_DELAY) |=>
            (clock_delay_en == $past(rif.wdata[`COT_BIT_CLK_DLY]) &&
            data_delay_en == $past(rif.wdata[`COT_BIT_DATA_DLY]));
    endproperty
    a_delay_en: assert property (p_delay_en) else $error("delay enables wrong");

    property p_delay_sel;
        @(posedge mclk) disable iff (!rst_b)
        (rif.wr && rif.addr == `COT_OFS_OUT_DELAY) |=>
            (fine_delay_sel == $past(rif.wdata[2:0]) && $stable(phase_sel));
    endproperty
    a_delay_sel: assert property (p_delay_sel) else $error("delay select wrong");

    property p_span_reset;
        @(posedge mclk) disable iff (!rst_b)
        first_after_reset |-> (reference_span_code == `COT_RST_SPAN);
    endproperty
    a_span_reset: assert property (p_span_reset) else $error("span reset wrong");

    property p_pattern_hi;
        @(posedge mclk) disable iff (!rst_b)
        (rif.wr && rif.addr == `COT_OFS_PAT2_HI) |=>
            (pattern_two[15:8] == $past(rif.wdata)) && $stable(pattern_two[7:0]);
    endproperty
    a_pattern_hi: assert property (p_pattern_hi) else $error("pattern high byte wrong");

    property p_live;
        @(posedge mclk) disable iff (!rst_b)
        (rif.wr && rif.addr == `COT_OFS_REF_SPAN) |=> ##0
            (reference_span_code == $past(rif.wdata[2:0]));
    endproperty
    a_live: assert property (p_live) else $error("span write not applied");

    c_invert_on: cover property (@(posedge mclk) disable iff (!rst_b) $rose(invert));
    c_both_delays: cover property (@(posedge mclk) disable iff (!rst_b)
        clock_delay_en && data_delay_en);
    c_read_frame: cover property (@(posedge mclk) disable iff (!rst_b) $fell(sdio_oe_b));
endmodule : cot_timing_regs

/* cot_params.svh */
// Offsets, field positions, reset values and counts of the timing register set
`ifndef COT_PARAMS_SVH
`define COT_PARAMS_SVH

`define COT_ADDR_W 13
`define COT_OFS_CLK_PHASE 13'h016
`define COT_OFS_OUT_DELAY 13'h017
`define COT_OFS_REF_SPAN 13'h018
`define COT_OFS_PAT1_LO 13'h019
`define COT_OFS_PAT1_HI 13'h01a
`define COT_OFS_PAT2_LO 13'h01b
`define COT_OFS_PAT2_HI 13'h01c

`define COT_BIT_INVERT 7
`define COT_BIT_CLK_DLY 7
`define COT_BIT_DATA_DLY 5
`define COT_FLD_LO 0
`define COT_FLD_HI 2

`define COT_RST_BYTE 8'h00
`define COT_RST_FIELD 3'h0
`define COT_RST_SPAN 3'h4
`define COT_READ_NONE 8'h00

`define COT_DIV_MSB 2
`define COT_HIST_W 8
`define COT_INSTR_LAST 4'hf
`define COT_BYTE_LAST 3'h7
`define COT_RW_BIT 15

`endif

/* cot_pkg.sv */
// Types shared by the timing register set
package cot_pkg;
    typedef enum logic [0:0] {
        COT_ST_INSTR = 1'b0,
        COT_ST_DATA = 1'b1
    } cot_spi_state_t;
endpackage : cot_pkg

/* cot_reg_if.sv */
// Register access path between the serial port and the register bank
`timescale 1ns/1ps
interface cot_reg_if;
    logic wr;
    logic [12:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport master (output wr, output addr, output wdata, input rdata);
    modport slave (input wr, input addr, input wdata, output rdata);
endinterface : cot_reg_if

/* cot_spi_port.sv */
// Serial control port: 16-bit instruction, then streamed bytes MSB first
`timescale 1ns/1ps
`include "cot_params.svh"
module cot_spi_port (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Serial pins
    input wire logic sclk,
    input wire logic csb,
    input wire logic sdio_i,
    output logic sdio_o,
    output logic sdio_oe_b,
    // Register side
    cot_reg_if.master rif
);
    function automatic logic [15:0] shift_in(input logic [15:0] cur, input logic bit_in);
        shift_in = {cur[14:0], bit_in};
    endfunction : shift_in

    cot_pkg::cot_spi_state_t state;
    logic sclk_q;
    logic rise;
    logic fall;
    logic [3:0] cnt;
    logic [15:0] sh;
    logic [15:0] next_sh;
    logic is_read;
    logic byte_done;
    logic load_req;
    logic [7:0] tx;
    logic [12:0] addr;

    assign rise = sclk & ~sclk_q & ~csb;
    assign fall = ~sclk & sclk_q & ~csb;
    assign next_sh = shift_in(sh, sdio_i);
    assign rif.addr = addr;
    assign rif.wdata = sh[7:0];
    assign rif.wr = byte_done & ~is_read;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk;
        end
    end

    // Frame sequencing; chip select high aborts any frame
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= cot_pkg::COT_ST_INSTR;
            cnt <= 4'h0;
            sh <= 16'h0000;
            is_read <= 1'b0;
            addr <= 13'h0000;
            byte_done <= 1'b0;
            load_req <= 1'b0;
        end else begin
            byte_done <= 1'b0;
            load_req <= byte_done;
            if (csb) begin
                state <= cot_pkg::COT_ST_INSTR;
                cnt <= 4'h0;
            end else if (rise) begin
                sh <= next_sh;
                cnt <= cnt + 4'h1;
                if (state == cot_pkg::COT_ST_INSTR && cnt == `COT_INSTR_LAST) begin
                    state <= cot_pkg::COT_ST_DATA;
                    is_read <= next_sh[`COT_RW_BIT];
                    addr <= next_sh[12:0];
                    cnt <= 4'h0;
                    load_req <= 1'b1;
                end else if (state == cot_pkg::COT_ST_DATA && cnt[2:0] == `COT_BYTE_LAST) begin
                    cnt <= 4'h0;
                    byte_done <= 1'b1;
                end
            end
            // Streaming walks downward, one byte per address
            if (byte_done) begin
                addr <= addr - 13'h0001;
            end
        end
    end

    // Read data leaves on falling edges so the host samples on rising ones
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tx <= `COT_READ_NONE;
            sdio_o <= 1'b0;
            sdio_oe_b <= 1'b1;
        end else begin
            sdio_oe_b <= ~(~csb & state == cot_pkg::COT_ST_DATA & is_read);
            if (load_req) begin
                tx <= rif.rdata;
            end else if (fall && state == cot_pkg::COT_ST_DATA && is_read) begin
                sdio_o <= tx[7];
                tx <= {tx[6:0], 1'b0};
            end
        end
    end
endmodule : cot_spi_port

/* cot_host_model.sv */
// Host model of the serial control port, the party that drives each frame
`timescale 1ns/1ps
module cot_host_model (
    // Clock
    input wire logic mclk,
    // Serial pins
    output logic sclk,
    output logic csb,
    output logic sdio_i,
    input wire logic sdio_o,
    input wire logic sdio_oe_b
);
    logic h_bit;
    logic h_en;
    int half = 5;

    // Shared line: device, else host, else the pull-down
    assign sdio_i = !sdio_oe_b ? sdio_o : (h_en ? h_bit : 1'b0);

    initial begin
        sclk = 1'b0;
        csb = 1'b1;
        h_bit = 1'b0;
        h_en = 1'b0;
    end

    // Sixteen instruction bits then one byte, MSB first
    task automatic xfer(input logic [15:0] ins, input logic [7:0] wd, output logic [7:0] rd);
        rd = 8'h00;
        @(negedge mclk);
        csb = 1'b0;
        repeat (4) @(negedge mclk);
        for (int i = 0; i < 24; i++) begin
            // Host lets go of the line for read data
            h_en = (i < 16) || !ins[15];
            h_bit = (i < 16) ? ins[15 - i] : wd[23 - i];
            repeat (half) @(negedge mclk);
            sclk = 1'b1;
            if (i >= 16) begin
                rd[23 - i] = sdio_i;
            end
            repeat (half) @(negedge mclk);
            sclk = 1'b0;
        end
        repeat (half) @(negedge mclk);
        csb = 1'b1;
        h_en = 1'b0;
        repeat (half) @(negedge mclk);
    endtask : xfer
endmodule : cot_host_model

/* testbench.sv */
// Self-checking bench for the timing register set
`timescale 1ns/1ps
module testbench;
    logic mclk, rst_b, sclk, csb, sdio_i, sdio_o, sdio_oe_b;
    logic idc, odc, cde, dde;
    logic [2:0] fsel, span;
    logic [15:0] pat1, pat2;
    logic [7:0] mem [8'h16:8'h1c];
    logic [7:0] msk [8'h16:8'h1c];
    logic [7:0] d;
    int error_cnt, tests_run, p0, p;
    int cyc = 0;

    cot_timing_regs dut (.mclk(mclk), .rst_b(rst_b), .sclk(sclk), .csb(csb),
        .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_b(sdio_oe_b),
        .input_divider_clock(idc), .output_data_clock(odc), .clock_delay_en(cde),
        .data_delay_en(dde), .fine_delay_sel(fsel), .reference_span_code(span),
        .pattern_one(pat1), .pattern_two(pat2));
    cot_host_model host (.mclk(mclk), .sclk(sclk), .csb(csb), .sdio_i(sdio_i),
        .sdio_o(sdio_o), .sdio_oe_b(sdio_oe_b));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;

    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task end_sim;
        $display("error_cnt=%0d tests_run=%0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim

    task wr(input logic [7:0] a, input logic [7:0] v);
        logic [7:0] r;
        host.xfer({8'h00, a}, v, r);
        chk(sdio_oe_b, 1'b1);
        // Open bits and unmapped places keep nothing
        if (a inside {[8'h16:8'h1c]}) mem[a] = v & msk[a];
    endtask : wr

    task rdchk(input logic [7:0] a);
        logic [7:0] r;
        host.xfer({8'h80, a}, 8'h00, r);
        chk(r, (a inside {[8'h16:8'h1c]}) ? mem[a] : 8'h00);
    endtask : rdchk

    task chk_ports;
        chk({cde, dde, fsel}, {mem[8'h17][7], mem[8'h17][5], mem[8'h17][2:0]});
        chk(span, mem[8'h18][2:0]);
        chk(pat1, {mem[8'h1a], mem[8'h19]});
        chk(pat2, {mem[8'h1c], mem[8'h1b]});
    endtask : chk_ports

    // Offset of the next divider rise within the eight-cycle period
    task rise(output int pos);
        int n;
        n = 0;
        while (idc !== 1'b0 && n < 40) begin @(negedge mclk); n++; end
        while (idc !== 1'b1 && n < 40) begin @(negedge mclk); n++; end
        if (n >= 40) begin
            error_cnt++;
            end_sim;
        end else begin
            pos = cyc % 8;
        end
    endtask : rise

    initial begin
        rst_b = 1'b0;
        for (int a = 8'h16; a <= 8'h1c; a++) begin
            mem[a] = 8'h00;
            msk[a] = 8'hff;
        end
        mem[8'h18] = 8'h04;
        msk[8'h16] = 8'h87;
        msk[8'h17] = 8'ha7;
        msk[8'h18] = 8'h07;
        void'($urandom(32'h09f6));
        repeat (4) @(negedge mclk);
        rst_b = 1'b1;
        @(negedge mclk);
        for (int a = 8'h16; a <= 8'h1c; a++) begin
            rdchk(8'(a));
        end
        chk_ports;
        // Slow host first, then the fastest legal one
        for (int k = 0; k < 2; k++) begin
            host.half = k ? 4 : 9;
            for (int a = 8'h16; a <= 8'h1c; a++) begin
                d = 8'($urandom);
                if (a == 8'h17) begin
                    wr(8'h17, d & 8'h07);
                end
                wr(8'(a), d);
                chk_ports;
                rdchk(8'(a));
            end
        end
        wr(8'h20, 8'($urandom));
        rdchk(8'h20);
        chk_ports;
        wr(8'h16, 8'h00);
        repeat (16) @(negedge mclk);
        rise(p0);
        for (int k = 0; k < 16; k++) begin
            wr(8'h16, 8'(((k & 8) << 4) | (k & 7)));
            repeat (16) @(negedge mclk);
            rise(p);
            chk(16'(p), 16'((p0 + (k & 7)) % 8));
            for (int j = 0; j < 8; j++) begin
                chk(odc, idc ^ k[3]);
                @(negedge mclk);
            end
        end
        end_sim;
    end
endmodule : testbench
